/* File: design/lwc_pkg.sv */
package lwc_pkg;

   // Chip operating modes as seen by this block.
   typedef enum logic [3:0] {
      LWC_OP_SHUTDOWN,
      LWC_OP_CONFIG,
      LWC_OP_POWERUP,
      LWC_OP_RESET,
      LWC_OP_STARTUP,
      LWC_OP_NORMAL,
      LWC_OP_FLASH,
      LWC_OP_STANDBY,
      LWC_OP_SLEEP,
      LWC_OP_FAILSAFE
   } lwc_opmode_e;

   // Transceiver function.
   typedef enum logic [1:0] {
      LWC_TRX_OFF,
      LWC_TRX_WAKE,
      LWC_TRX_RXONLY,
      LWC_TRX_NORMAL
   } lwc_trx_e;

   localparam logic [1:0] LWC_FIELD_OFF = 2'h0;
   localparam logic [1:0] LWC_FIELD_WAKE = 2'h1;
   localparam logic [1:0] LWC_FIELD_RXONLY = 2'h2;
   localparam logic [1:0] LWC_FIELD_NORMAL = 2'h3;

   // Wake edge select encoding.
   localparam logic [1:0] LWC_EDGE_NONE = 2'h0;
   localparam logic [1:0] LWC_EDGE_RISE = 2'h1;
   localparam logic [1:0] LWC_EDGE_FALL = 2'h2;
   localparam logic [1:0] LWC_EDGE_BOTH = 2'h3;

   localparam int LWC_CLK_PERIOD_NS = 100;
   localparam int LWC_DOM_TIMEOUT_US = 20;
   localparam int LWC_BUS_WAKE_US = 150;
   localparam int LWC_WAKE_FILT_US = 50;
   localparam int LWC_DOM_TIMEOUT_CYC = (LWC_DOM_TIMEOUT_US * 1000) / LWC_CLK_PERIOD_NS;
   localparam int LWC_BUS_WAKE_CYC =
      (LWC_BUS_WAKE_US * 1000 + LWC_CLK_PERIOD_NS - 1) / LWC_CLK_PERIOD_NS;
   localparam int LWC_WAKE_FILT_CYC =
      (LWC_WAKE_FILT_US * 1000 + LWC_CLK_PERIOD_NS - 1) / LWC_CLK_PERIOD_NS;
   localparam int LWC_CNT_W = 16;

endpackage

/* File: design/lwc_trx_if.sv */
`timescale 1ns/10ps
interface lwc_trx_if;
   import lwc_pkg::*;
   lwc_trx_e func;
   logic tx_n;
   logic bus_rx;
   logic batt_low;
   logic timeout_en;
   logic wake_clr;
   logic rx_n;
   logic drive_dom;
   logic wake_evt;
   logic timed_out;

   modport ctrl (output func, tx_n, bus_rx, batt_low, timeout_en, wake_clr,
                 input rx_n, drive_dom, wake_evt, timed_out);
   modport trx (input func, tx_n, bus_rx, batt_low, timeout_en, wake_clr,
                output rx_n, drive_dom, wake_evt, timed_out);
endinterface

/* File: design/lwc_trx.sv */
`timescale 1ns/10ps
module lwc_trx
   import lwc_pkg::*;
#(
   parameter int DOM_TIMEOUT_CYC = LWC_DOM_TIMEOUT_CYC,
   parameter int BUS_WAKE_CYC = LWC_BUS_WAKE_CYC
) (
   input wire logic core_clk_i,
   input wire logic reset_output_n_i,
   lwc_trx_if.trx t
);
   logic [LWC_CNT_W-1:0] dom_cnt_r;
   logic [LWC_CNT_W-1:0] wdom_cnt_r;
   logic timed_out_r;
   logic wake_arm_r;
   logic woke_r;
   logic wake_evt_r;
   logic rx_n_r;
   logic drive_dom_r;

   // Dominant time-out on the transmit input.
   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         dom_cnt_r <= '0;
         timed_out_r <= 1'b0;
      end else if (t.tx_n || t.func != LWC_TRX_NORMAL || !t.timeout_en) begin
         dom_cnt_r <= '0;
         timed_out_r <= 1'b0;
      end else if (dom_cnt_r >= LWC_CNT_W'(DOM_TIMEOUT_CYC)) begin
         timed_out_r <= 1'b1;
      end else begin
         dom_cnt_r <= dom_cnt_r + 1'b1;
      end
   end

   // Bus wake: a long dominant followed by recessive.
   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         wdom_cnt_r <= '0;
         wake_arm_r <= 1'b0;
         woke_r <= 1'b0;
         wake_evt_r <= 1'b0;
      end else begin
         wake_evt_r <= 1'b0;
         if (t.func != LWC_TRX_WAKE) begin
            wdom_cnt_r <= '0;
            wake_arm_r <= 1'b0;
            woke_r <= 1'b0;
         end else if (!t.bus_rx) begin
            if (wdom_cnt_r >= LWC_CNT_W'(BUS_WAKE_CYC - 1)) begin
               wake_arm_r <= 1'b1;
            end else begin
               wdom_cnt_r <= wdom_cnt_r + 1'b1;
            end
         end else begin
            wdom_cnt_r <= '0;
            wake_arm_r <= 1'b0;
            if (wake_arm_r) begin
               woke_r <= 1'b1;
               wake_evt_r <= 1'b1;
            end else if (t.wake_clr) begin
               woke_r <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         rx_n_r <= 1'b1;
         drive_dom_r <= 1'b0;
      end else begin
         unique case (t.func)
            LWC_TRX_OFF: rx_n_r <= 1'b1;
            LWC_TRX_WAKE: rx_n_r <= !woke_r;
            LWC_TRX_RXONLY: rx_n_r <= t.bus_rx;
            LWC_TRX_NORMAL: rx_n_r <= t.bus_rx;
         endcase
         drive_dom_r <= t.func == LWC_TRX_NORMAL && !t.tx_n && !timed_out_r
                        && !t.batt_low;
      end
   end

   assign t.rx_n = rx_n_r;
   assign t.drive_dom = drive_dom_r;
   assign t.wake_evt = wake_evt_r;
   assign t.timed_out = timed_out_r;
endmodule

/* File: design/lwc_wake_pin.sv */
`timescale 1ns/10ps
module lwc_wake_pin
   import lwc_pkg::*;
#(
   parameter int FILT_CYC = LWC_WAKE_FILT_CYC
) (
   input wire logic core_clk_i,
   input wire logic reset_output_n_i,
   input wire logic level_i,
   input wire logic [1:0] edge_sel_i,
   output logic filt_o,
   output logic rise_o,
   output logic fall_o
);
   logic [LWC_CNT_W-1:0] cnt_r;
   logic filt_r;
   logic rise_r;
   logic fall_r;

   // Filtered level flips only after the input holds for the filter time.
   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         cnt_r <= '0;
         filt_r <= 1'b0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         rise_r <= 1'b0;
         fall_r <= 1'b0;
         if (level_i == filt_r) begin
            cnt_r <= '0;
         end else if (cnt_r >= LWC_CNT_W'(FILT_CYC)) begin
            cnt_r <= '0;
            filt_r <= level_i;
            rise_r <= level_i && (edge_sel_i == LWC_EDGE_RISE
                                  || edge_sel_i == LWC_EDGE_BOTH);
            fall_r <= !level_i && (edge_sel_i == LWC_EDGE_FALL
                                   || edge_sel_i == LWC_EDGE_BOTH);
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   assign filt_o = filt_r;
   assign rise_o = rise_r;
   assign fall_o = fall_r;
endmodule

/* File: design/lwc_top.sv */
`timescale 1ns/10ps
module lwc_top
   import lwc_pkg::*;
#(
   parameter int NUM_TRX = 2,
   parameter int DOM_TIMEOUT_CYC = LWC_DOM_TIMEOUT_CYC,
   parameter int BUS_WAKE_CYC = LWC_BUS_WAKE_CYC,
   parameter int WAKE_FILT_CYC = LWC_WAKE_FILT_CYC
) (
   input wire logic core_clk_i,
   input wire logic reset_output_n_i,
   input wire logic [3:0] op_mode_i,
   input wire logic thermal_shutdown_i,
   input wire logic [2*NUM_TRX-1:0] bus_transceiver_mode_field_i,
   input wire logic [NUM_TRX-1:0] bus_transmit_input_i,
   input wire logic [NUM_TRX-1:0] bus_line_rx_i,
   input wire logic timeout_enable_i,
   input wire logic low_slope_i,
   input wire logic battery_low_cmp_i,
   input wire logic local_wake_pin_i,
   input wire logic [1:0] wake_edge_select_i,
   input wire logic wake_pin_event_flag_clr_i,
   input wire logic [NUM_TRX-1:0] bus_wake_clr_i,
   input wire logic mid_supply_below_low_i,
   input wire logic mid_supply_above_high_i,
   output logic [NUM_TRX-1:0] bus_receive_output_o,
   output logic [NUM_TRX-1:0] bus_line_pin_dom_o,
   output logic [NUM_TRX-1:0] bus_line_pin_strong_pullup_o,
   output logic [NUM_TRX-1:0] low_slope_o,
   output logic [NUM_TRX-1:0] dom_timeout_status_o,
   output logic battery_low_status_o,
   output logic wake_pin_level_status_o,
   output logic wake_pin_pullup_o,
   output logic wake_pin_pulldown_o,
   output logic wake_pin_event_flag_o,
   output logic irq_req_o,
   output logic reset_req_o,
   output logic shutdown_o,
   output logic enter_config_o,
   output logic main_logic_supply_en_o,
   output logic auxiliary_supply_off_o,
   output logic reset_output_n_o,
   output logic undervoltage_output_n_o,
   output logic serial_out_oe_o
);
   logic [NUM_TRX-1:0] tx_s1_r, tx_s2_r, bus_s1_r, bus_s2_r;
   logic bat_s1_r, bat_s2_r, wk_s1_r, wk_s2_r;
   logic shut_r;
   lwc_opmode_e mode;
   logic functional;
   logic wake_filt, wake_rise, wake_fall;
   logic [NUM_TRX-1:0] bus_wake_evt;
   logic [NUM_TRX-1:0] rx_n_w, dom_w, to_w;
   lwc_trx_e func_w [NUM_TRX];
   logic wake_pin_event_flag_r, irq_req_r, reset_req_r, enter_config_r;
   logic battery_low_status_r, wake_pin_level_status_r;
   logic wake_pin_pullup_r, wake_pin_pulldown_r, shutdown_r;
   logic [NUM_TRX-1:0] rx_out_r, dom_out_r, pu_r, slope_r, to_r;

   assign mode = lwc_opmode_e'(op_mode_i);
   assign functional = mode == LWC_OP_STARTUP || mode == LWC_OP_NORMAL
                       || mode == LWC_OP_FLASH || mode == LWC_OP_STANDBY;

   // Transmit, bus receive, battery and wake pins pass two flip-flops; the supply and thermal inputs do not.
   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         tx_s1_r <= '1;
         tx_s2_r <= '1;
         bus_s1_r <= '1;
         bus_s2_r <= '1;
         bat_s1_r <= 1'b0;
         bat_s2_r <= 1'b0;
         wk_s1_r <= 1'b0;
         wk_s2_r <= 1'b0;
      end else begin
         tx_s1_r <= bus_transmit_input_i;
         tx_s2_r <= tx_s1_r;
         bus_s1_r <= bus_line_rx_i;
         bus_s2_r <= bus_s1_r;
         bat_s1_r <= battery_low_cmp_i;
         bat_s2_r <= bat_s1_r;
         wk_s1_r <= local_wake_pin_i;
         wk_s2_r <= wk_s1_r;
      end
   end

   // Shut-down entry is asynchronous; exit waits for the high threshold.
   always_ff @(posedge core_clk_i or negedge reset_output_n_i or posedge mid_supply_below_low_i) begin
      if (!reset_output_n_i) begin
         shut_r <= 1'b1;
      end else if (mid_supply_below_low_i) begin
         shut_r <= 1'b1;
      end else if (mid_supply_above_high_i) begin
         shut_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         enter_config_r <= 1'b0;
         shutdown_r <= 1'b1;
      end else begin
         shutdown_r <= shut_r;
         enter_config_r <= shutdown_r && !shut_r;
      end
   end

   function automatic lwc_trx_e decode(input lwc_opmode_e m, input logic [1:0] f,
                                       input logic tsd, input logic sd);
      lwc_trx_e r;
      r = LWC_TRX_OFF;
      if (sd) begin
         r = LWC_TRX_OFF;
      end else begin
         unique case (m)
            LWC_OP_STARTUP, LWC_OP_NORMAL, LWC_OP_FLASH, LWC_OP_STANDBY: begin
               r = lwc_trx_e'(f);
            end
            LWC_OP_SLEEP: begin
               r = (f == LWC_FIELD_WAKE) ? LWC_TRX_WAKE : LWC_TRX_OFF;
            end
            LWC_OP_FAILSAFE: begin
               r = tsd ? LWC_TRX_OFF : LWC_TRX_WAKE;
            end
            default: begin
               r = LWC_TRX_OFF;
            end
         endcase
      end
      return r;
   endfunction

   genvar g;
   generate
      for (g = 0; g < NUM_TRX; g++) begin : gen_trx
         lwc_trx_if ti ();
         assign func_w[g] = decode(mode, bus_transceiver_mode_field_i[2*g +: 2],
                                   thermal_shutdown_i, shut_r);
         assign ti.func = func_w[g];
         assign ti.tx_n = tx_s2_r[g];
         assign ti.bus_rx = bus_s2_r[g];
         assign ti.batt_low = bat_s2_r;
         assign ti.timeout_en = timeout_enable_i;
         assign ti.wake_clr = bus_wake_clr_i[g];
         assign rx_n_w[g] = ti.rx_n;
         assign dom_w[g] = ti.drive_dom;
         assign bus_wake_evt[g] = ti.wake_evt;
         assign to_w[g] = ti.timed_out;
         lwc_trx #(
            .DOM_TIMEOUT_CYC(DOM_TIMEOUT_CYC),
            .BUS_WAKE_CYC(BUS_WAKE_CYC)
         ) u_trx (
            .core_clk_i(core_clk_i),
            .reset_output_n_i(reset_output_n_i),
            .t(ti.trx)
         );
      end
   endgenerate

   lwc_wake_pin #(
      .FILT_CYC(WAKE_FILT_CYC)
   ) u_wake (
      .core_clk_i(core_clk_i),
      .reset_output_n_i(reset_output_n_i),
      .level_i(wk_s2_r),
      .edge_sel_i(wake_edge_select_i),
      .filt_o(wake_filt),
      .rise_o(wake_rise),
      .fall_o(wake_fall)
   );

   // Transceiver outputs; receive held high in shut-down.
   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         rx_out_r <= '1;
         dom_out_r <= '0;
         pu_r <= '0;
         slope_r <= '0;
         to_r <= '0;
      end else begin
         rx_out_r <= shut_r ? '1 : rx_n_w;
         dom_out_r <= dom_w;
         for (int i = 0; i < NUM_TRX; i++) begin
            pu_r[i] <= func_w[i] == LWC_TRX_NORMAL;
            slope_r[i] <= low_slope_i && func_w[i] == LWC_TRX_NORMAL;
         end
         to_r <= to_w;
      end
   end

   // Wake pin status and bias.
   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         battery_low_status_r <= 1'b0;
         wake_pin_level_status_r <= 1'b0;
         wake_pin_pullup_r <= 1'b0;
         wake_pin_pulldown_r <= 1'b1;
      end else begin
         battery_low_status_r <= bat_s2_r;
         if (functional && !shut_r) begin
            wake_pin_level_status_r <= wk_s2_r;
         end
         wake_pin_pullup_r <= wake_filt;
         wake_pin_pulldown_r <= !wake_filt;
      end
   end

   // Sticky wake flag: a new edge wins over a clear in the same cycle.
   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         wake_pin_event_flag_r <= 1'b0;
      end else if (!shut_r && (wake_rise || wake_fall)
                   && (functional || mode == LWC_OP_SLEEP)) begin
         wake_pin_event_flag_r <= 1'b1;
      end else if (wake_pin_event_flag_clr_i) begin
         wake_pin_event_flag_r <= 1'b0;
      end
   end

   // Wake events become one-cycle interrupt or reset requests.
   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         irq_req_r <= 1'b0;
         reset_req_r <= 1'b0;
      end else begin
         irq_req_r <= !shut_r && functional
                      && ((|bus_wake_evt) || wake_rise || wake_fall);
         reset_req_r <= !shut_r && (mode == LWC_OP_SLEEP || mode == LWC_OP_FAILSAFE)
                        && ((|bus_wake_evt)
                            || (mode == LWC_OP_SLEEP && (wake_rise || wake_fall)));
      end
   end

   assign bus_receive_output_o = rx_out_r;
   assign bus_line_pin_dom_o = dom_out_r;
   assign bus_line_pin_strong_pullup_o = pu_r;
   assign low_slope_o = slope_r;
   assign dom_timeout_status_o = to_r;
   assign battery_low_status_o = battery_low_status_r;
   assign wake_pin_level_status_o = wake_pin_level_status_r;
   assign wake_pin_pullup_o = wake_pin_pullup_r;
   assign wake_pin_pulldown_o = wake_pin_pulldown_r;
   assign wake_pin_event_flag_o = wake_pin_event_flag_r;
   assign irq_req_o = irq_req_r;
   assign reset_req_o = reset_req_r;
   assign shutdown_o = shutdown_r;
   assign enter_config_o = enter_config_r;
   // Supplies and digital outputs follow the registered shut-down state.
   assign main_logic_supply_en_o = !shutdown_r;
   assign auxiliary_supply_off_o = shutdown_r;
   assign reset_output_n_o = !shutdown_r;
   assign undervoltage_output_n_o = !shutdown_r;
   assign serial_out_oe_o = !shutdown_r;
endmodule

/* File: tb/lwc_top_checker.sv */
`timescale 1ns/10ps
module lwc_top_checker
   import lwc_pkg::*;
#(
   parameter int NUM_TRX = 2,
   parameter int DOM_TIMEOUT_CYC = LWC_DOM_TIMEOUT_CYC
) (
   input wire logic core_clk_i,
   input wire logic reset_output_n_i,
   input wire logic [3:0] op_mode_i,
   input wire logic [2*NUM_TRX-1:0] bus_transceiver_mode_field_i,
   input wire logic [NUM_TRX-1:0] bus_transmit_input_i,
   input wire logic timeout_enable_i,
   input wire logic battery_low_cmp_i,
   input wire logic wake_pin_event_flag_clr_i,
   input wire logic mid_supply_below_low_i,
   input wire logic [NUM_TRX-1:0] bus_receive_output_o,
   input wire logic [NUM_TRX-1:0] bus_line_pin_dom_o,
   input wire logic battery_low_status_o,
   input wire logic wake_pin_event_flag_o,
   input wire logic shutdown_o,
   input wire logic enter_config_o,
   input wire logic main_logic_supply_en_o,
   input wire logic auxiliary_supply_off_o,
   input wire logic reset_output_n_o,
   input wire logic undervoltage_output_n_o,
   input wire logic serial_out_oe_o
);
   logic [7:0] low_cnt_r;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_output_n_i);

   // Counts how long transmitter 0 has asked for dominant with the time-out armed.
   always_ff @(posedge core_clk_i or negedge reset_output_n_i) begin
      if (!reset_output_n_i) begin
         low_cnt_r <= 8'h00;
      end else if (bus_transmit_input_i[0] || !timeout_enable_i) begin
         low_cnt_r <= 8'h00;
      end else if (low_cnt_r != 8'hff) begin
         low_cnt_r <= low_cnt_r + 8'h01;
      end
   end

   chk_off_rx_high: assert property (
      (op_mode_i == LWC_OP_POWERUP || op_mode_i == LWC_OP_RESET)[*3] |-> &bus_receive_output_o)
      else $error("receive output low while transceivers are off");
   chk_tx_dom_path: assert property (
      (op_mode_i == LWC_OP_NORMAL && bus_transceiver_mode_field_i[1:0] == LWC_FIELD_NORMAL &&
      !battery_low_cmp_i && !timeout_enable_i && !bus_transmit_input_i[0])[*5]
      |-> bus_line_pin_dom_o[0])
      else $error("transmit low not sent as dominant");
   chk_no_tx_other: assert property (
      (bus_transceiver_mode_field_i[1:0] != LWC_FIELD_NORMAL)[*3] |-> !bus_line_pin_dom_o[0])
      else $error("dominant driven outside normal function");
   chk_batt_block: assert property (
      battery_low_cmp_i[*5] |-> bus_line_pin_dom_o == '0)
      else $error("dominant driven while battery low");
   chk_batt_status: assert property (
      (!shutdown_o && $stable(battery_low_cmp_i))[*4] |->
      battery_low_status_o == battery_low_cmp_i)
      else $error("battery status does not follow comparator");
   chk_timeout_cut: assert property (
      low_cnt_r > DOM_TIMEOUT_CYC + 5 |-> !bus_line_pin_dom_o[0])
      else $error("long dominant not cut off");
   chk_sd_outputs: assert property (
      shutdown_o |-> !main_logic_supply_en_o && auxiliary_supply_off_o && !reset_output_n_o &&
      !undervoltage_output_n_o && !serial_out_oe_o)
      else $error("outputs active in shut-down");
   chk_sd_async: assert property (
      mid_supply_below_low_i |=> shutdown_o)
      else $error("low supply without shut-down");
   chk_config_entry: assert property (
      $fell(shutdown_o) |-> ##[0:1] enter_config_o)
      else $error("shut-down left without configuration entry");
   chk_flag_sticky: assert property (
      wake_pin_event_flag_o && !wake_pin_event_flag_clr_i |=> wake_pin_event_flag_o || shutdown_o)
      else $error("wake flag lost without clear");
endmodule

bind lwc_top lwc_top_checker #(.NUM_TRX(NUM_TRX), .DOM_TIMEOUT_CYC(DOM_TIMEOUT_CYC)) u_chk (
   .core_clk_i(core_clk_i), .reset_output_n_i(reset_output_n_i), .op_mode_i(op_mode_i),
   .bus_transceiver_mode_field_i(bus_transceiver_mode_field_i),
   .bus_transmit_input_i(bus_transmit_input_i), .timeout_enable_i(timeout_enable_i),
   .battery_low_cmp_i(battery_low_cmp_i), .wake_pin_event_flag_clr_i(wake_pin_event_flag_clr_i),
   .mid_supply_below_low_i(mid_supply_below_low_i), .bus_receive_output_o(bus_receive_output_o),
   .bus_line_pin_dom_o(bus_line_pin_dom_o), .battery_low_status_o(battery_low_status_o),
   .wake_pin_event_flag_o(wake_pin_event_flag_o), .shutdown_o(shutdown_o),
   .enter_config_o(enter_config_o), .main_logic_supply_en_o(main_logic_supply_en_o),
   .auxiliary_supply_off_o(auxiliary_supply_off_o), .reset_output_n_o(reset_output_n_o),
   .undervoltage_output_n_o(undervoltage_output_n_o), .serial_out_oe_o(serial_out_oe_o)
);

/* File: tb/lwc_lin_host_model.sv */
`timescale 1ns/10ps
module lwc_lin_host_model (
   input wire logic core_clk_i,
   output logic [1:0] tx_o
);
   initial tx_o = 2'h3;

   // Sends one dominant of len cycles; three scenarios ask for one beyond the time-out.
   task automatic send_dom(input int ch, input int len);
      @(posedge core_clk_i);
      tx_o[ch] <= 1'b0;
      repeat (len) @(posedge core_clk_i);
      tx_o[ch] <= 1'b1;
   endtask
endmodule

/* File: tb/lwc_top_tb.sv */
`timescale 1ns/10ps
module lwc_top_tb;
   import lwc_pkg::*;
   logic core_clk_i = 1'b0;
   logic reset_output_n_i = 1'b0;
   logic [3:0] op = 4'h0;
   logic [3:0] fld = 4'h0;
   logic [1:0] esel = 2'h0;
   logic [1:0] other_dom = 2'h0;
   logic [1:0] bclr = 2'h0;
   logic tsd = 1'b0, to_en = 1'b0, ls = 1'b0, batt = 1'b0, wpin = 1'b0, fclr = 1'b0;
   logic below = 1'b0, above = 1'b0, irq_seen = 1'b0, rst_seen = 1'b0, cfg_seen = 1'b0;
   logic [1:0] tx, rx, dom, pu, slope, tmo;
   logic bstat, wstat, wpu, wpd, wflag, irq, rreq, sd, cfg, main_logic_supply, aux, rst_n, uv_n, oe;
   int failures = 0;
   int checks_done = 0;
   int cyc = 0;
   lwc_opmode_e mlist [9] = '{LWC_OP_POWERUP, LWC_OP_RESET, LWC_OP_STARTUP, LWC_OP_NORMAL,
      LWC_OP_FLASH, LWC_OP_STANDBY, LWC_OP_SLEEP, LWC_OP_FAILSAFE, LWC_OP_FAILSAFE};

   lwc_top #(.DOM_TIMEOUT_CYC(6), .BUS_WAKE_CYC(8), .WAKE_FILT_CYC(5)) u_lwc_top (
      .core_clk_i(core_clk_i), .reset_output_n_i(reset_output_n_i), .op_mode_i(op), .thermal_shutdown_i(tsd),
      .bus_transceiver_mode_field_i(fld), .bus_transmit_input_i(tx),
      .bus_line_rx_i(~(dom | other_dom)), .timeout_enable_i(to_en), .low_slope_i(ls),
      .battery_low_cmp_i(batt), .local_wake_pin_i(wpin), .wake_edge_select_i(esel),
      .wake_pin_event_flag_clr_i(fclr), .bus_wake_clr_i(bclr), .mid_supply_below_low_i(below),
      .mid_supply_above_high_i(above), .bus_receive_output_o(rx), .bus_line_pin_dom_o(dom),
      .bus_line_pin_strong_pullup_o(pu), .low_slope_o(slope), .dom_timeout_status_o(tmo),
      .battery_low_status_o(bstat), .wake_pin_level_status_o(wstat), .wake_pin_pullup_o(wpu),
      .wake_pin_pulldown_o(wpd), .wake_pin_event_flag_o(wflag), .irq_req_o(irq),
      .reset_req_o(rreq), .shutdown_o(sd), .enter_config_o(cfg), .main_logic_supply_en_o(main_logic_supply),
      .auxiliary_supply_off_o(aux), .reset_output_n_o(rst_n), .undervoltage_output_n_o(uv_n),
      .serial_out_oe_o(oe));
   lwc_lin_host_model u_lwc_lin_host_model (.core_clk_i(core_clk_i), .tx_o(tx));

   always #50 core_clk_i = ~core_clk_i;

   // Pulse outputs are caught here so that a scenario can look at them later.
   always @(posedge core_clk_i) begin
      cyc++;
      if (irq) irq_seen = 1'b1;
      if (rreq) rst_seen = 1'b1;
      if (cfg) cfg_seen = 1'b1;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic look(input int n);
      repeat (n) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask

   task automatic set_mode(input logic [3:0] m, input logic [3:0] f, input logic t);
      @(negedge core_clk_i);
      irq_seen = 1'b0;
      rst_seen = 1'b0;
      @(posedge core_clk_i);
      op <= m;
      fld <= f;
      tsd <= t;
   endtask

   task automatic pulse_clr(input logic f, input logic [1:0] b);
      @(posedge core_clk_i);
      fclr <= f;
      bclr <= b;
      @(posedge core_clk_i);
      fclr <= 1'b0;
      bclr <= 2'h0;
   endtask

   function automatic int exp_fn(input logic [3:0] m, input logic [1:0] f, input logic t);
      case (m)
         LWC_OP_STARTUP, LWC_OP_NORMAL, LWC_OP_FLASH, LWC_OP_STANDBY: return int'(f);
         LWC_OP_SLEEP: return (f == LWC_FIELD_WAKE) ? 1 : 0;
         LWC_OP_FAILSAFE: return t ? 0 : 1;
         default: return 0;
      endcase
   endfunction

   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      int e, e1;
      repeat (4) @(posedge core_clk_i);
      reset_output_n_i <= 1'b1;
      look(2);
      chk("shutdown", 2'h1, sd);
      chk("rx_sd", 2'h3, rx);
      chk("rst_n_sd", 2'h0, rst_n);
      @(posedge core_clk_i);
      above <= 1'b1;
      look(4);
      chk("sd_exit", 2'h0, sd);
      chk("cfg_entry", 2'h1, cfg_seen);
      $display("Test power done");
      for (int k = 0; k < 9; k++) begin
         for (int f = 0; f < 4; f++) begin
            e = exp_fn(mlist[k], 2'(f), k == 8);
            e1 = exp_fn(mlist[k], 2'(f ^ 1), k == 8);
            set_mode(mlist[k], {2'(f ^ 1), 2'(f)}, k == 8);
            other_dom <= 2'h3;
            look(5);
            chk("rx_decode", {e1 < 2, e < 2}, rx);
            chk("pullup_decode", {e1 == 3, e == 3}, pu);
            @(posedge core_clk_i);
            other_dom <= 2'h0;
            look(5);
            chk("rx_idle", 2'h3, rx);
         end
      end
      $display("Test decode done");
      set_mode(LWC_OP_NORMAL, 4'hf, 1'b0);
      fork
         u_lwc_lin_host_model.send_dom(0, 20);
         begin
            look(9);
            chk("tx_dom", 2'h1, dom);
            chk("rx_own", 2'h2, rx);
            look(8);
            chk("no_timeout", 2'h1, dom);
         end
      join
      @(posedge core_clk_i);
      to_en <= 1'b1;
      fork
         u_lwc_lin_host_model.send_dom(0, 24);
         begin
            look(16);
            chk("tmo_cut", 2'h0, dom);
            chk("tmo_status", 2'h1, tmo);
            chk("rx_alive", 2'h3, rx);
            @(posedge core_clk_i);
            other_dom <= 2'h1;
            look(5);
            chk("rx_alive_dom", 2'h2, rx);
            @(posedge core_clk_i);
            other_dom <= 2'h0;
         end
      join
      look(5);
      chk("tmo_clear", 2'h0, tmo);
      fork
         u_lwc_lin_host_model.send_dom(0, 4);
         begin
            look(5);
            chk("tx_again", 2'h1, dom);
         end
      join
      $display("Test transmit done");
      set_mode(LWC_OP_NORMAL, 4'ha, 1'b0);
      fork
         u_lwc_lin_host_model.send_dom(0, 6);
         begin
            look(5);
            chk("rxonly_tx", 2'h0, dom);
         end
      join
      set_mode(LWC_OP_NORMAL, 4'hf, 1'b0);
      batt <= 1'b1;
      look(4);
      fork
         u_lwc_lin_host_model.send_dom(0, 16);
         begin
            look(14);
            chk("batt_block", 2'h0, dom);
            chk("batt_tmo", 2'h1, tmo);
            chk("batt_status", 2'h1, bstat);
         end
      join
      @(posedge core_clk_i);
      batt <= 1'b0;
      ls <= 1'b1;
      look(4);
      chk("batt_status_clr", 2'h0, bstat);
      chk("low_slope", 2'h3, slope);
      $display("Test supply done");
      set_mode(LWC_OP_SLEEP, 4'h5, 1'b0);
      other_dom <= 2'h1;
      look(11);
      @(posedge core_clk_i);
      other_dom <= 2'h0;
      look(6);
      chk("bus_wake_rx", 2'h2, rx);
      chk("bus_wake_rst", 2'h1, rst_seen);
      pulse_clr(1'b0, 2'h1);
      set_mode(LWC_OP_STANDBY, 4'h5, 1'b0);
      other_dom <= 2'h1;
      look(40);
      chk("stuck_rx", 2'h3, rx);
      chk("stuck_irq", 2'h0, irq_seen);
      @(posedge core_clk_i);
      other_dom <= 2'h0;
      look(6);
      chk("bus_wake_irq", 2'h1, irq_seen);
      chk("bus_wake_low", 2'h2, rx);
      pulse_clr(1'b0, 2'h1);
      $display("Test bus wake done");
      set_mode(LWC_OP_NORMAL, 4'hf, 1'b0);
      esel <= LWC_EDGE_RISE;
      wpin <= 1'b1;
      look(12);
      chk("wake_pullup", 2'h2, {wpu, wpd});
      chk("wake_level", 2'h1, wstat);
      chk("wake_rise", 2'h1, wflag);
      chk("wake_irq", 2'h1, irq_seen);
      pulse_clr(1'b1, 2'h0);
      esel <= LWC_EDGE_FALL;
      wpin <= 1'b0;
      look(12);
      chk("wake_pulldown", 2'h1, {wpu, wpd});
      chk("wake_level_low", 2'h0, wstat);
      chk("wake_fall", 2'h1, wflag);
      pulse_clr(1'b1, 2'h0);
      esel <= LWC_EDGE_NONE;
      wpin <= 1'b1;
      look(12);
      chk("wake_none", 2'h0, wflag);
      set_mode(LWC_OP_SLEEP, 4'h0, 1'b0);
      esel <= LWC_EDGE_BOTH;
      wpin <= 1'b0;
      look(12);
      chk("wake_both", 2'h1, wflag);
      chk("wake_reset", 2'h1, rst_seen);
      $display("Test wake pin done");
      @(posedge core_clk_i);
      below <= 1'b1;
      cfg_seen = 1'b0;
      look(1);
      chk("sd_async", 2'h1, sd);
      look(2);
      chk("sd_rx", 2'h3, rx);
      chk("sd_supply", 2'h1, {main_logic_supply, aux});
      @(posedge core_clk_i);
      below <= 1'b0;
      look(4);
      chk("sd_leave", 2'h1, {sd, cfg_seen});
      $display("Test shutdown done");
      tally_and_finish();
   end
endmodule
